// ---- hw/swt_params.svh ----
// constants of the wake and timeout supervision block
// Contract
// - transmit dominant timeout after configured time
// - record transmit timeout in pollable flag
// - silence timer restarts on every bus edge
// - wake only after dominant longer than filter
// - failed wake returns to low power
// - bias on within delay of criterion
// - very short dominant pulses are ignored
// - longer dominant pulses restart recessive counter
// - valid FD frames leave error counter unchanged
// - recessive FDF and next bit flag error
// - bias switched automatically, no host needed
// - silence and tolerance only with selective wake
// - bias off in sleep and wake pending, on in normal and standby
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH

`define SWT_CLK_KHZ 25000
`define SWT_DOMINANT_TIMEOUT_TIME_US 4000
`define SWT_DOMINANT_TIMEOUT_CYC \
  ((`SWT_DOMINANT_TIMEOUT_TIME_US * `SWT_CLK_KHZ) / 1000)
`define SWT_BUS_SILENCE_TIMEOUT_MS 900
`define SWT_BUS_SILENCE_CYC (`SWT_BUS_SILENCE_TIMEOUT_MS * `SWT_CLK_KHZ)
`define SWT_WAKE_ACTIVITY_FILTER_TIME_NS 2000
`define SWT_WAKE_FILTER_CYC \
  ((`SWT_WAKE_ACTIVITY_FILTER_TIME_NS * `SWT_CLK_KHZ + 999999) / 1000000)
`define SWT_WAKE_TIMEOUT_US 5000
`define SWT_WAKE_TIMEOUT_CYC ((`SWT_WAKE_TIMEOUT_US * `SWT_CLK_KHZ) / 1000)
`define SWT_BIAS_ACTIVATION_DELAY_US 100
`define SWT_BIAS_DELAY_CYC \
  ((`SWT_BIAS_ACTIVATION_DELAY_US * `SWT_CLK_KHZ) / 1000)
`define SWT_IFS_BITS 11

`define SWT_OFF_CTRL 12'h000
`define SWT_OFF_STATUS 12'h004
`define SWT_OFF_BITTIME 12'h008
`define SWT_OFF_ERRCNT 12'h00C

`define SWT_CTRL_MODE_LSB 0
`define SWT_CTRL_SW_EN 2
`define SWT_CTRL_FD_ERR_EN 3
`define SWT_ST_DOMINANT_TIMEOUT_TIME 0
`define SWT_ST_SILENCE 1
`define SWT_ST_WAKE 2
`define SWT_ST_BIAS 3
`define SWT_ST_LOW_POWER 4
`define SWT_ST_IDLE 5
`define SWT_ST_MODE_LSB 6

`define SWT_BITTIME_RESET 8'h32
`define SWT_SW_EN_RESET 1'b1
`define SWT_FD_ERR_EN_RESET 1'b1

`endif

// ---- hw/swt_pkg.sv ----
// types of the wake and timeout supervision block
package swt_pkg;

  typedef enum logic [1:0] {
    SWT_NORMAL,
    SWT_STANDBY,
    SWT_SLEEP,
    SWT_WAKE_PEND
  } swt_mode_t;

  typedef struct packed {
    logic [7:0] dom_len;
    logic [7:0] phase;
    logic [4:0] bit_cnt;
    logic idle;
  } swt_ifs_state_t;

  typedef struct packed {
    swt_mode_t mode;
    logic sw_en;
    logic fd_err_en;
    logic [7:0] bit_cyc;
    logic [7:0] err_cnt;
    logic [16:0] dominant_timeout_time_cnt;
    logic dominant_timeout_time_act;
    logic dominant_timeout_time_flag;
    logic [24:0] sil_cnt;
    logic sil_flag;
    logic [16:0] wake_cnt;
    logic [7:0] filt_cnt;
    logic wake_flag;
    logic [11:0] bias_cnt;
    logic bias_on;
    logic low_power;
    logic bus_prev;
    logic fdf_rec;
    logic txd_bus;
    logic rxd;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } swt_state_t;

endpackage

// ---- hw/swt_ifs_if.sv ----
// link between top and the recessive bit counter
`timescale 1ns/1ps
`default_nettype none
interface swt_ifs_if;
  logic bus_dom;
  logic tol_en;
  logic [7:0] bit_cyc;
  logic idle;
  logic restart;
  modport top (output bus_dom, output tol_en, output bit_cyc,
    input idle, input restart);
  modport cnt (input bus_dom, input tol_en, input bit_cyc,
    output idle, output restart);
endinterface
`default_nettype wire

// ---- hw/swt_ifs.sv ----
// recessive bit counter with short pulse tolerance
`timescale 1ns/1ps
`default_nettype none
`include "swt_params.svh"
module swt_ifs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // counter link
  swt_ifs_if.cnt ifs
);
  import swt_pkg::*;

  localparam logic [4:0] IFS_BITS = 5'(`SWT_IFS_BITS);

  swt_ifs_state_t s_q, s_d;
  logic [11:0] dom_x10;
  logic long_pulse;

  always_comb begin
    s_d = s_q;
    dom_x10 = {1'b0, s_q.dom_len, 3'b0} + {3'b0, s_q.dom_len, 1'b0};
    // tolerance threshold at tenth of bit
    long_pulse = ifs.tol_en ? (dom_x10 > {4'h0, ifs.bit_cyc})
                            : (s_q.dom_len != 8'h00);
    if (ifs.bus_dom) begin
      if (s_q.dom_len != 8'hFF) begin
        s_d.dom_len = s_q.dom_len + 8'h01;
      end
    end else begin
      s_d.dom_len = 8'h00;
    end
    if (s_q.phase + 8'h01 >= ifs.bit_cyc) begin
      s_d.phase = 8'h00;
      if (!ifs.bus_dom && s_q.bit_cnt != IFS_BITS) begin
        s_d.bit_cnt = s_q.bit_cnt + 5'h01;
      end
    end else begin
      s_d.phase = s_q.phase + 8'h01;
    end
    if (s_d.bit_cnt == IFS_BITS) begin
      s_d.idle = 1'b1;
    end
    if (ifs.bus_dom && long_pulse) begin
      s_d.phase = 8'h00;
      s_d.bit_cnt = 5'h00;
      s_d.idle = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ifs.idle = s_q.idle;
  assign ifs.restart = ifs.bus_dom && long_pulse;

endmodule
`default_nettype wire

// ---- hw/swt_top.sv ----
// wake and timeout supervision logic with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "swt_params.svh"
module swt_top #(
  parameter int unsigned DOMINANT_TIMEOUT_TIME_CYC = `SWT_DOMINANT_TIMEOUT_CYC,
  parameter int unsigned SILENCE_CYC = `SWT_BUS_SILENCE_CYC,
  parameter int unsigned WAKE_CYC = `SWT_WAKE_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // protocol controller side
  input wire logic txd,
  output logic rxd,
  // bus side, low is dominant
  input wire logic bus_rx,
  output logic txd_bus,
  output logic bias_on,
  output logic low_power,
  output logic silence_expired,
  // frame position marks from the wake frame decoder
  input wire logic fdf_mark,
  input wire logic post_fdf_mark,
  input wire logic fd_frame_ok
);
  import swt_pkg::*;

  localparam logic [7:0] FILT_CYC = 8'(`SWT_WAKE_FILTER_CYC);
  localparam logic [11:0] BIAS_CYC = 12'(`SWT_BIAS_DELAY_CYC);
  localparam logic [16:0] DOMINANT_TIMEOUT_TIME_END = 17'(DOMINANT_TIMEOUT_TIME_CYC);
  localparam logic [24:0] SIL_END = 25'(SILENCE_CYC);
  localparam logic [16:0] WAKE_END = 17'(WAKE_CYC);

  swt_state_t s_q, s_d;
  swt_ifs_if ifs ();
  logic access;
  logic wr;
  logic bus_dom;
  logic bus_edge;
  logic bias_crit;
  logic [31:0] status;
  logic [31:0] rdata;
  logic hit;

  swt_ifs u_ifs (
    .pclk(pclk),
    .presetn(presetn),
    .ifs(ifs.cnt)
  );

  assign bus_dom = !bus_rx;
  assign ifs.bus_dom = bus_dom;
  assign ifs.tol_en = s_q.sw_en;
  assign ifs.bit_cyc = s_q.bit_cyc;

  // second cycle of the access phase answers
  assign access = psel && penable && !s_q.pready;
  assign wr = access && pwrite;

  always_comb begin
    status = 32'h0;
    status[`SWT_ST_DOMINANT_TIMEOUT_TIME] = s_q.dominant_timeout_time_flag;
    status[`SWT_ST_SILENCE] = s_q.sil_flag;
    status[`SWT_ST_WAKE] = s_q.wake_flag;
    status[`SWT_ST_BIAS] = s_q.bias_on;
    status[`SWT_ST_LOW_POWER] = s_q.low_power;
    status[`SWT_ST_IDLE] = ifs.idle;
    status[`SWT_ST_MODE_LSB +: 2] = s_q.mode;
  end

  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    case (paddr)
      `SWT_OFF_CTRL: begin
        rdata[`SWT_CTRL_MODE_LSB +: 2] = s_q.mode;
        rdata[`SWT_CTRL_SW_EN] = s_q.sw_en;
        rdata[`SWT_CTRL_FD_ERR_EN] = s_q.fd_err_en;
      end
      `SWT_OFF_STATUS: begin
        rdata = status;
      end
      `SWT_OFF_BITTIME: begin
        rdata[7:0] = s_q.bit_cyc;
      end
      `SWT_OFF_ERRCNT: begin
        rdata[7:0] = s_q.err_cnt;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    bus_edge = bus_rx != s_q.bus_prev;
    s_d.bus_prev = bus_rx;

    // apb answer
    s_d.pready = access;
    s_d.pslverr = access && !hit;
    s_d.prdata = (access && !pwrite && hit) ? rdata : 32'h0;

    // software writes; sticky flags cleared by writing one
    if (wr && hit) begin
      case (paddr)
        `SWT_OFF_CTRL: begin
          s_d.mode = swt_mode_t'(pwdata[`SWT_CTRL_MODE_LSB +: 2]);
          if (pwdata[`SWT_CTRL_MODE_LSB +: 2] == SWT_WAKE_PEND) begin
            s_d.mode = SWT_SLEEP;
          end
          s_d.sw_en = pwdata[`SWT_CTRL_SW_EN];
          s_d.fd_err_en = pwdata[`SWT_CTRL_FD_ERR_EN];
          s_d.wake_cnt = 17'h0;
          s_d.filt_cnt = 8'h0;
        end
        `SWT_OFF_STATUS: begin
          if (pwdata[`SWT_ST_DOMINANT_TIMEOUT_TIME]) begin
            s_d.dominant_timeout_time_flag = 1'b0;
          end
          if (pwdata[`SWT_ST_SILENCE]) begin
            s_d.sil_flag = 1'b0;
          end
          if (pwdata[`SWT_ST_WAKE]) begin
            s_d.wake_flag = 1'b0;
          end
        end
        `SWT_OFF_BITTIME: begin
          s_d.bit_cyc = pwdata[7:0];
        end
        `SWT_OFF_ERRCNT: begin
          s_d.err_cnt = 8'h0;
        end
        default: begin
          s_d.bit_cyc = s_q.bit_cyc;
        end
      endcase
    end

    if (txd) begin
      s_d.dominant_timeout_time_cnt = 17'h0;
      s_d.dominant_timeout_time_act = 1'b0;
    end else if (s_q.dominant_timeout_time_cnt + 17'h1 >= DOMINANT_TIMEOUT_TIME_END) begin
      s_d.dominant_timeout_time_act = 1'b1;
      s_d.dominant_timeout_time_flag = 1'b1;
    end else begin
      s_d.dominant_timeout_time_cnt = s_q.dominant_timeout_time_cnt + 17'h1;
    end
    s_d.txd_bus = txd || s_d.dominant_timeout_time_act
      || s_q.mode == SWT_SLEEP || s_q.mode == SWT_WAKE_PEND;

    // silence timer restarts on bus edge
    if (!s_q.sw_en || bus_edge) begin
      s_d.sil_cnt = 25'h0;
    end else if (s_q.sil_cnt + 25'h1 >= SIL_END) begin
      s_d.sil_flag = 1'b1;
    end else begin
      s_d.sil_cnt = s_q.sil_cnt + 25'h1;
    end

    // low power wake handling
    case (s_q.mode)
      SWT_SLEEP: begin
        s_d.low_power = 1'b1;
        s_d.filt_cnt = 8'h0;
        s_d.wake_cnt = 17'h0;
        if (bus_dom) begin
          s_d.mode = SWT_WAKE_PEND;
          s_d.low_power = 1'b0;
        end
      end
      SWT_WAKE_PEND: begin
        s_d.wake_cnt = s_q.wake_cnt + 17'h1;
        s_d.filt_cnt = bus_dom ? s_q.filt_cnt + 8'h1 : 8'h0;
        // dominant longer than filter time wakes
        if (bus_dom && s_q.filt_cnt >= FILT_CYC) begin
          s_d.wake_flag = 1'b1;
          s_d.mode = SWT_STANDBY;
        // failed wake returns to low power
        end else if (s_q.wake_cnt + 17'h1 >= WAKE_END) begin
          s_d.mode = SWT_SLEEP;
          s_d.low_power = 1'b1;
        end
      end
      SWT_STANDBY: begin
        s_d.low_power = 1'b0;
      end
      SWT_NORMAL: begin
        s_d.low_power = 1'b0;
      end
      default: begin
        s_d.mode = SWT_STANDBY;
      end
    endcase

    // wake shows as held low receive output until cleared, except in normal mode where receive follows the bus
    if (s_q.mode == SWT_NORMAL) begin
      s_d.rxd = bus_rx;
    end else begin
      s_d.rxd = !s_q.wake_flag;
    end

    bias_crit = s_q.mode == SWT_NORMAL || s_q.mode == SWT_STANDBY;
    if (!bias_crit) begin
      s_d.bias_cnt = 12'h0;
      s_d.bias_on = 1'b0;
    end else if (s_q.bias_cnt + 12'h1 >= BIAS_CYC) begin
      s_d.bias_on = 1'b1;
    end else begin
      s_d.bias_cnt = s_q.bias_cnt + 12'h1;
    end

    // recessive FDF then recessive next bit
    if (fdf_mark) begin
      s_d.fdf_rec = bus_rx;
    end
    if (post_fdf_mark && s_q.fdf_rec && bus_rx && s_q.fd_err_en
        && s_q.err_cnt != 8'hFF) begin
      s_d.err_cnt = s_q.err_cnt + 8'h1;
    end
    if (fd_frame_ok) begin
      s_d.fdf_rec = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mode <= SWT_STANDBY;
      s_q.sw_en <= `SWT_SW_EN_RESET;
      s_q.fd_err_en <= `SWT_FD_ERR_EN_RESET;
      s_q.bit_cyc <= `SWT_BITTIME_RESET;
      s_q.bus_prev <= 1'b1;
      s_q.txd_bus <= 1'b1;
      s_q.rxd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign prdata = s_q.prdata;
  assign rxd = s_q.rxd;
  assign txd_bus = s_q.txd_bus;
  assign bias_on = s_q.bias_on;
  assign low_power = s_q.low_power;
  assign silence_expired = s_q.sil_flag;

endmodule
`default_nettype wire

// ---- dv/swt_asserts.sv ----
// port assertions of the wake and timeout supervision block
`timescale 1ns/1ps
`default_nettype none
module swt_asserts #(
  parameter int unsigned DOMINANT_TIMEOUT_TIME_CYC = 40,
  parameter int unsigned SILENCE_CYC = 100
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // lines
  input wire logic txd,
  input wire logic bus_rx,
  input wire logic txd_bus,
  input wire logic bias_on,
  input wire logic low_power,
  input wire logic silence_expired
);
  int tcnt;
  int scnt;
  int bcnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) tcnt <= 0;
    else tcnt <= txd ? 0 : tcnt + 1;
  // cycles since the last bus edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) scnt <= 0;
    else scnt <= $changed(bus_rx) ? 0 : scnt + 1;
  // awake cycles with bias still off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) bcnt <= 0;
    else bcnt <= (bias_on || low_power) ? 0 : bcnt + 1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_txd_recessive: assert property (txd |=> txd_bus)
    else $error("txd_bus dominant after recessive txd");
  a_dominant_timeout_time_force: assert property (tcnt > DOMINANT_TIMEOUT_TIME_CYC + 1 |-> txd_bus)
    else $error("txd_bus not forced after dominant timeout");
  a_bias_sleep: assert property (
    low_power && $past(low_power) |-> !bias_on)
    else $error("bias on in sleep");
  a_bias_delay: assert property (bcnt < 2700)
    else $error("bias not on in time");
  a_apb_answer: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_silence_restart: assert property (
    $rose(silence_expired) |-> scnt >= SILENCE_CYC - 2)
    else $error("silence flag before quiet time");
endmodule
bind swt_top swt_asserts #(.DOMINANT_TIMEOUT_TIME_CYC(DOMINANT_TIMEOUT_TIME_CYC),
  .SILENCE_CYC(SILENCE_CYC)) chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .txd(txd),
  .bus_rx(bus_rx),
  .txd_bus(txd_bus),
  .bias_on(bias_on),
  .low_power(low_power),
  .silence_expired(silence_expired)
);
`default_nettype wire

// ---- dv/swt_ctl_model.sv ----
// protocol controller model driving transmit data
`timescale 1ns/1ps
`default_nettype none
module swt_ctl_model #(
  parameter int LEN = 60
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command and line
  input wire logic go,
  output logic txd
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt <= 0;
    else if (go) cnt <= LEN;
    else if (cnt > 0) cnt <= cnt - 1;
  // recessive outside a commanded dominant hold
  assign txd = (cnt == 0);
endmodule
`default_nettype wire

// ---- dv/tb_selective_wake_timeout_logic.sv ----
// bench for the wake and timeout supervision block
`timescale 1ns/1ps
`default_nettype none
module tb_selective_wake_timeout_logic;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd_q, prdata;
  logic txd_go = 0, bus_rx = 1, fdf_mark = 0, post_fdf_mark = 0;
  logic fd_frame_ok = 0, err_q, pready, pslverr, rxd, txd, txd_bus;
  logic bias_on, low_power, silence_expired;
  int failures = 0, num_checks = 0, cyc = 0;
  initial forever #20 pclk = ~pclk;
  swt_top #(.DOMINANT_TIMEOUT_TIME_CYC(40), .SILENCE_CYC(100), .WAKE_CYC(200)) dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .txd(txd),
    .rxd(rxd),
    .bus_rx(bus_rx),
    .txd_bus(txd_bus),
    .bias_on(bias_on),
    .low_power(low_power),
    .silence_expired(silence_expired),
    .fdf_mark(fdf_mark),
    .post_fdf_mark(post_fdf_mark),
    .fd_frame_ok(fd_frame_ok)
  );
  swt_ctl_model ctl (.pclk(pclk), .presetn(presetn), .go(txd_go),
    .txd(txd));
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic mark(input logic f, p);
    bus_rx <= f;
    fdf_mark <= 1;
    wt(1);
    fdf_mark <= 0;
    bus_rx <= p;
    post_fdf_mark <= 1;
    wt(1);
    post_fdf_mark <= 0;
    bus_rx <= 1;
  endtask
  initial begin
    wt(16);
    presetn <= 1;
    xfer(0, 12'h000, 0);
    chk(rd_q, 32'hD);
    xfer(0, 12'h010, 0);
    chk({err_q, rd_q[30:0]}, 32'h80000000);
    wt(2600);
    chk(bias_on, 1'h1);
    tdone("reset");
    xfer(1, 12'h000, 32'hC);
    txd_go <= 1;
    wt(1);
    txd_go <= 0;
    wt(20);
    chk(txd_bus, 1'h0);
    wt(30);
    chk(txd_bus, 1'h1);
    xfer(0, 12'h004, 0);
    chk(rd_q[0], 1'h1);
    wt(20);
    xfer(1, 12'h004, 32'h1);
    xfer(0, 12'h004, 0);
    chk(rd_q[0], 1'h0);
    tdone("timeout");
    for (int i = 0; i < 6; i++) begin
      bus_rx <= ~bus_rx;
      wt(50);
      if (i == 0) xfer(1, 12'h004, 32'h2);
    end
    chk(silence_expired, 1'h0);
    wt(60);
    chk(silence_expired, 1'h1);
    tdone("silence");
    // silence timer idle while selective wake is off
    xfer(1, 12'h000, 32'h8);
    xfer(1, 12'h004, 32'h2);
    wt(150);
    chk(silence_expired, 1'h0);
    xfer(1, 12'h000, 32'hC);
    tdone("sw_off");
    wt(600);
    xfer(0, 12'h004, 0);
    chk(rd_q[5], 1'h1);
    for (int i = 0; i < 2; i++) begin
      bus_rx <= 0;
      wt(i ? 20 : 2);
      bus_rx <= 1;
      xfer(0, 12'h004, 0);
      chk(rd_q[5], i ? 1'h0 : 1'h1);
    end
    tdone("interframe");
    mark(1'h1, 1'h0);
    fd_frame_ok <= 1;
    wt(1);
    fd_frame_ok <= 0;
    xfer(0, 12'h00C, 0);
    chk(rd_q, 32'h0);
    mark(1'h1, 1'h1);
    xfer(0, 12'h00C, 0);
    chk(rd_q, 32'h1);
    xfer(1, 12'h00C, 0);
    xfer(0, 12'h00C, 0);
    chk(rd_q, 32'h0);
    tdone("fd");
    xfer(1, 12'h000, 32'hE);
    wt(5);
    chk(low_power, 1'h1);
    chk(bias_on, 1'h0);
    bus_rx <= 0;
    wt(20);
    bus_rx <= 1;
    wt(10);
    chk(low_power, 1'h0);
    chk(rxd, 1'h1);
    wt(220);
    chk(low_power, 1'h1);
    bus_rx <= 0;
    wt(60);
    chk(rxd, 1'h0);
    bus_rx <= 1;
    wt(2600);
    chk(bias_on, 1'h1);
    tdone("wake");
    print_verdict();
  end
endmodule
`default_nettype wire
